// >>> tb/fxir_host_model.sv
// host processor model on the parallel bus
`timescale 1ns/1ps
`default_nettype none
module fxir_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [3:0] addr,
    output logic      [7:0] wdata
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
    end
    task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (4) @(negedge clk);
        q = rdata;
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        addr = ~a;
        wdata = ~d;
        repeat (3) @(negedge clk);
    endtask : acc
endmodule : fxir_host_model
`default_nettype wire

// >>> tb/fxir_irq_monitor.sv
// checker for interrupt, clear pulse and routing relations
`timescale 1ns/1ps
`default_nettype none
module fxir_irq_monitor (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     cs_n,
    input wire logic                     wr_n,
    input wire logic [3:0]               addr,
    input wire fxir_pkg::fxir_mode_type  mode,
    input wire logic [6:0]               irq_enable,
    input wire fxir_pkg::fxir_event_type core_event,
    input wire logic                     image_req,
    input wire logic                     recorder_ready_in,
    input wire logic                     xfer_counter_clear,
    input wire logic                     proc_counter_clear,
    input wire fxir_pkg::fxir_route_type route,
    input wire logic                     dma_request_out,
    input wire logic                     image_in_valid,
    input wire logic                     irq_out
);
    localparam logic [5:0] RT [0:7] = '{6'h30, 6'h28, 6'h21, 6'h14, 6'h12, 6'h05, 6'h0A, 6'h00};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_event_irq: assert property (
        core_event.xfer_done && irq_enable[0] && mode <= fxir_pkg::MODE_G2_TO_G3
        |-> ##2 irq_out)
        else $error("irq missing after transfer-line event");
    chk_masked_quiet: assert property (
        (irq_enable == 7'h00)[*3] |-> !irq_out)
        else $error("irq raised with all sources disabled");
    chk_dma_gate: assert property (
        dma_request_out == (image_req && (route.image_in_en || route.image_out_en)))
        else $error("dma request not gated by image route");
    chk_route_map: assert property (
        !$past(rst) |-> route == RT[$past(mode)])
        else $error("route does not match mode");
    chk_xfer_wr_clear: assert property (
        $rose(wr_n) && !cs_n && addr == fxir_pkg::ADDR_XFER_CLEAR |-> ##[3:5] xfer_counter_clear)
        else $error("no transfer counter clear after write");
    chk_proc_wr_clear: assert property (
        $rose(wr_n) && !cs_n && addr == fxir_pkg::ADDR_PROC_CLEAR |-> ##[3:5] proc_counter_clear)
        else $error("no process counter clear after write");
    chk_clear_addr: assert property (
        xfer_counter_clear |-> $past(addr, 2) == fxir_pkg::ADDR_XFER_CLEAR)
        else $error("transfer counter clear without its address");
    chk_recrdy_irq: assert property (
        (recorder_ready_in && irq_enable[4] && mode == fxir_pkg::MODE_COPY)[*6] |-> irq_out)
        else $error("irq missing while recorder ready");
    cover property (image_in_valid);
    cover property (proc_counter_clear);
    cover property ($fell(irq_out));
endmodule : fxir_irq_monitor
bind fxir_irq_route fxir_irq_monitor mon (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
    .addr(addr), .mode(mode), .irq_enable(irq_enable), .core_event(core_event),
    .image_req(image_req), .recorder_ready_in(recorder_ready_in),
    .xfer_counter_clear(xfer_counter_clear), .proc_counter_clear(proc_counter_clear),
    .route(route), .dma_request_out(dma_request_out), .image_in_valid(image_in_valid),
    .irq_out(irq_out));
`default_nettype wire

// >>> tb/fxir_irq_route_test.sv
// self-checking bench for the interrupt and routing block
`timescale 1ns/1ps
`default_nettype none
module fxir_irq_route_test;
    localparam logic [5:0] ALW [0:6] = '{6'h19, 6'h03, 6'h29, 6'h15, 6'h39, 6'h25, 6'h23};
    localparam logic [5:0] RT [0:6] = '{6'h30, 6'h28, 6'h21, 6'h14, 6'h12, 6'h05, 6'h0A};
    localparam logic [3:0] CZ [0:5] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h4, 4'h8};
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    wire                      cs_n, rd_n, wr_n, img_v, xclr, pclr, dma, irq;
    wire  [3:0]               addr;
    wire  [7:0]               wdata, rdata, img_in;
    fxir_pkg::fxir_mode_type  mode;
    fxir_pkg::fxir_event_type ev;
    fxir_pkg::fxir_route_type route;
    logic [6:0]               en;
    logic [7:0]               dec_d, cod_d, img_d, q, wd;
    logic                     img_req, rec_rdy;
    int                       n_fail = 0, checks = 0, m, s;
    int                       n_xclr = 0, n_pclr = 0;
    logic [7:0]               exp_q[$];
    initial begin
        forever #2.5 clk = ~clk;
    end
    fxir_host_model hm (.clk(clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .wdata(wdata));
    fxir_irq_route DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .wdata(wdata), .rdata(rdata), .mode(mode), .irq_enable(en),
        .core_event(ev), .decode_status_in(dec_d), .coded_first_in(cod_d),
        .image_out_data(img_d), .image_req(img_req), .recorder_ready_in(rec_rdy),
        .image_in_data(img_in), .image_in_valid(img_v), .xfer_counter_clear(xclr),
        .proc_counter_clear(pclr), .route(route), .dma_request_out(dma), .irq_out(irq));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic pulse(input logic [3:0] e);
        ev = e;
        @(negedge clk);
        ev = 4'h0;
        repeat (7) @(negedge clk);
    endtask : pulse
    always @(negedge clk) begin
        if (img_v === 1'b1) chk("img_in", img_in, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
        if (xclr === 1'b1) n_xclr++;
        if (pclr === 1'b1) n_pclr++;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        finish_test();
    end
    initial begin
        void'($urandom(29));
        mode = fxir_pkg::MODE_COPY;
        en = 7'h00;
        ev = 4'h0;
        img_req = 1'b0;
        rec_rdy = 1'b0;
        dec_d = 8'($urandom);
        cod_d = 8'($urandom);
        img_d = 8'($urandom);
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("irq_idle", {7'h00, irq}, 8'h00);
        for (m = 0; m < 7; m++) begin
            mode = fxir_pkg::fxir_mode_type'(m[2:0]);
            en = 7'h7F;
            repeat (2) @(negedge clk);
            chk("route", {2'b00, route}, {2'b00, RT[m]});
            for (s = 0; s < 6; s++) begin
                if (s == 4) rec_rdy = 1'b1;
                if (s == 5) img_req = 1'b1;
                pulse(s < 4 ? 4'(4'h8 >> s) : 4'h0);
                chk("irq_set", {7'h00, irq}, {7'h00, ALW[m][s]});
                if (s == 5) chk("dma", {7'h00, dma}, {7'h00, |RT[m][1:0]});
                if (ALW[m][s]) begin
                    hm.acc(1'b0, fxir_pkg::ADDR_CAUSE_STATUS, 8'h00, q);
                    chk("cause", {4'h0, q[3:0]}, {4'h0, CZ[s]});
                end
                rec_rdy = 1'b0;
                img_req = 1'b0;
                wd = 8'($urandom);
                case (s)
                    0: hm.acc(1'b1, fxir_pkg::ADDR_XFER_CLEAR, wd, q);
                    1: begin
                        hm.acc(1'b0, fxir_pkg::ADDR_CODED_FIRST, wd, q);
                        chk("coded", q, RT[m][3] ? cod_d : 8'h00);
                    end
                    2: begin
                        hm.acc(1'b0, fxir_pkg::ADDR_DECODE_STATUS, wd, q);
                        chk("decode", q, dec_d);
                    end
                    3: hm.acc(1'b1, fxir_pkg::ADDR_PROC_CLEAR, wd, q);
                    5: begin
                        if (RT[m][1]) exp_q.push_back(wd);
                        hm.acc(!RT[m][0], fxir_pkg::ADDR_IMAGE_DATA, wd, q);
                        if (RT[m][0]) chk("img_out", q, img_d);
                    end
                    default: ;
                endcase
                repeat (7) @(negedge clk);
                chk("irq_clr", {7'h00, irq}, 8'h00);
            end
        end
        mode = fxir_pkg::fxir_mode_type'(3'h7);
        pulse(4'hF);
        chk("route_off", {2'b00, route}, 8'h00);
        chk("irq_off", {7'h00, irq}, 8'h00);
        mode = fxir_pkg::MODE_COPY;
        en = 7'h76;
        pulse(4'h9);
        chk("irq_mask", {7'h00, irq}, 8'h00);
        en = 7'h7F;
        pulse(4'h9);
        hm.acc(1'b0, fxir_pkg::ADDR_CAUSE_STATUS, 8'h00, q);
        chk("cause_both", {4'h0, q[3:0]}, 8'h01);
        hm.acc(1'b1, fxir_pkg::ADDR_XFER_CLEAR, 8'h5A, q);
        hm.acc(1'b0, fxir_pkg::ADDR_CAUSE_STATUS, 8'h00, q);
        chk("cause_left", {4'h0, q[3:0]}, 8'h02);
        hm.acc(1'b1, fxir_pkg::ADDR_PROC_CLEAR, 8'hA5, q);
        repeat (7) @(negedge clk);
        chk("irq_end", {7'h00, irq}, 8'h00);
        chk("img_left", 8'(exp_q.size()), 8'h00);
        chk("xclr_cnt", 8'(n_xclr), 8'h08);
        chk("pclr_cnt", 8'(n_pclr), 8'h08);
        finish_test();
    end
endmodule : fxir_irq_route_test
`default_nettype wire

// >>> verilog/fxir_irq_route.sv
// interrupt sources, cause encoding and mode routing of the codec host side
// Summary of operation
// - seven sources, each enabled by host; disabled source never requests
// - host reads cause at 1H, bits D3..D0
// - transfer-line done shows 0001, cleared by write to CH
// - coding done shows 0010, cleared by read of 9H
// - decoding done shows 0010, cleared by read of 8H
// - process-line done shows 0010, cleared by write to EH
// - recorder ready shows 0100 while input active, clears itself
// - image output request shows 1000, cleared by read of 7H
// - image input request shows 1000, cleared by write of 7H
// - copy: transfer-line, recorder ready, process-line only
// - G3 send: transfer-line and coding only
// - G2 send: transfer-line, image output, process-line only
// - G3 receive: decoding, recorder ready, transfer-line only
// - G2 receive: image input, transfer-line, recorder ready, process-line
// - G3 to G2: decoding, image output, transfer-line only
// - G2 to G3: image input, transfer-line, coding only
// - scanner input accepted only in copy, G2 send, G3 send
// - recorder output only in copy, G2 receive, G3 receive
// - coded results offered on host bus in G3 send, G2 to G3
// - decoding data written by host in G3 receive, G3 to G2
// - host supplies image data in G2 receive, G2 to G3
// - device delivers image data in G2 send, G3 to G2
// - writes to CH and EH reset line counters, data ignored
`timescale 1ns/1ps
`default_nettype none

module fxir_irq_route (
    input  wire logic                    clk,
    input  wire logic                    rst,
    // host parallel bus, active-low strobes from pins
    input  wire logic                    cs_n,
    input  wire logic                    rd_n,
    input  wire logic                    wr_n,
    input  wire logic [3:0]              addr,
    input  wire logic [7:0]              wdata,
    output logic      [7:0]              rdata,
    // configuration from the command decoder
    input  wire fxir_pkg::fxir_mode_type mode,
    input  wire logic [6:0]              irq_enable,
    // codec core side
    input  wire fxir_pkg::fxir_event_type core_event,
    input  wire logic [7:0]              decode_status_in,
    input  wire logic [7:0]              coded_first_in,
    input  wire logic [7:0]              image_out_data,
    input  wire logic                    image_req,
    input  wire logic                    recorder_ready_in,
    output logic [7:0]                   image_in_data,
    output logic                         image_in_valid,
    output logic                         xfer_counter_clear,
    output logic                         proc_counter_clear,
    output fxir_pkg::fxir_route_type     route,
    output logic                         dma_request_out,
    output logic                         irq_out
);

    // ****************************************************************
    // pin synchronisers and strobe edges
    // ****************************************************************
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic       rd_seen_reg;
    logic       wr_seen_reg;
    logic       rd_pulse;
    logic       wr_pulse;
    logic [3:0] addr_meta_reg;
    logic [7:0] wdata_meta_reg;
    logic [3:0] addr_reg;
    logic [7:0] wdata_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {recorder_ready_in, ~cs_n & ~rd_n, ~cs_n & ~wr_n, 1'b0};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_seen_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
        end else begin
            rd_seen_reg <= pin_sync_reg[2];
            wr_seen_reg <= pin_sync_reg[1];
        end
    end

    // address and data pins pass two flops like the strobes
    // the host holds them stable across the strobe and after its release
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_meta_reg  <= 4'h0;
            wdata_meta_reg <= fxir_pkg::DATA_RESET;
            addr_reg       <= 4'h0;
            wdata_reg      <= fxir_pkg::DATA_RESET;
        end else begin
            addr_meta_reg  <= addr;
            wdata_meta_reg <= wdata;
            addr_reg       <= addr_meta_reg;
            wdata_reg      <= wdata_meta_reg;
        end
    end

    // read acts on strobe end, so the data has been taken before the clear
    assign rd_pulse = rd_seen_reg & ~pin_sync_reg[2];
    assign wr_pulse = wr_seen_reg & ~pin_sync_reg[1];

    logic recorder_ready_sync;
    assign recorder_ready_sync = pin_sync_reg[3];

    // ****************************************************************
    // mode routing
    // ****************************************************************
    logic [6:0] mode_allow;
    fxir_pkg::fxir_route_type route_next;

    always_comb begin
        mode_allow = 7'h00;
        route_next = '0;
        case (mode)
            fxir_pkg::MODE_COPY: begin
                mode_allow = 7'b0011001;
                route_next.scan_in_en = 1'b1;
                route_next.rec_out_en = 1'b1;
            end
            fxir_pkg::MODE_G3_SEND: begin
                mode_allow = 7'b0000011;
                route_next.scan_in_en   = 1'b1;
                route_next.coded_out_en = 1'b1;
            end
            fxir_pkg::MODE_G2_SEND: begin
                mode_allow = 7'b0101001;
                route_next.scan_in_en   = 1'b1;
                route_next.image_out_en = 1'b1;
            end
            fxir_pkg::MODE_G3_RECV: begin
                mode_allow = 7'b0010101;
                route_next.rec_out_en   = 1'b1;
                route_next.decode_in_en = 1'b1;
            end
            fxir_pkg::MODE_G2_RECV: begin
                mode_allow = 7'b1011001;
                route_next.rec_out_en  = 1'b1;
                route_next.image_in_en = 1'b1;
            end
            fxir_pkg::MODE_G3_TO_G2: begin
                mode_allow = 7'b0100101;
                route_next.decode_in_en = 1'b1;
                route_next.image_out_en = 1'b1;
            end
            fxir_pkg::MODE_G2_TO_G3: begin
                mode_allow = 7'b1000011;
                route_next.coded_out_en = 1'b1;
                route_next.image_in_en  = 1'b1;
            end
            default: begin
                mode_allow = 7'h00;
            end
        endcase
    end

    // scanner, recorder, coded, decoding and image paths gated by mode
    always_ff @(posedge clk) begin
        if (rst) begin
            route <= '0;
        end else begin
            route <= route_next;
        end
    end

    // ****************************************************************
    // register access decode
    // ****************************************************************
    logic rd_image;
    logic rd_decode;
    logic rd_coded;
    logic wr_image;
    logic wr_xfer;
    logic wr_proc;

    // reads of 7H outside image-out modes neither return data nor clear
    always_comb begin
        rd_image  = 1'b0;
        rd_decode = 1'b0;
        rd_coded  = 1'b0;
        wr_image  = 1'b0;
        wr_xfer   = 1'b0;
        wr_proc   = 1'b0;
        if (rd_pulse && addr_reg == fxir_pkg::ADDR_IMAGE_DATA) begin
            rd_image = route.image_out_en;
        end else if (rd_pulse && addr_reg == fxir_pkg::ADDR_DECODE_STATUS) begin
            rd_decode = 1'b1;
        end else if (rd_pulse && addr_reg == fxir_pkg::ADDR_CODED_FIRST) begin
            rd_coded = 1'b1;
        end
        if (wr_pulse && addr_reg == fxir_pkg::ADDR_IMAGE_DATA) begin
            wr_image = route.image_in_en;
        end else if (wr_pulse && addr_reg == fxir_pkg::ADDR_XFER_CLEAR) begin
            wr_xfer = 1'b1;
        end else if (wr_pulse && addr_reg == fxir_pkg::ADDR_PROC_CLEAR) begin
            wr_proc = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_counter_clear <= 1'b0;
            proc_counter_clear <= 1'b0;
        end else begin
            xfer_counter_clear <= wr_xfer;
            proc_counter_clear <= wr_proc;
        end
    end

    // host image data toward the line memory
    always_ff @(posedge clk) begin
        if (rst) begin
            image_in_data  <= fxir_pkg::DATA_RESET;
            image_in_valid <= 1'b0;
        end else begin
            image_in_valid <= wr_image;
            if (wr_image) begin
                image_in_data <= wdata_reg;
            end
        end
    end

    // ****************************************************************
    // pending sources, set wins over clear
    // ****************************************************************
    logic [6:0] pend_reg;
    logic [6:0] set_vec;
    logic [6:0] clr_vec;

    // image request drives dma line in its data direction
    assign dma_request_out = image_req & (route.image_in_en | route.image_out_en);

    always_comb begin
        set_vec = 7'h00;
        clr_vec = 7'h00;
        set_vec[fxir_pkg::SRC_XFER]   = core_event.xfer_done;
        set_vec[fxir_pkg::SRC_CODE]   = core_event.code_done;
        set_vec[fxir_pkg::SRC_DECODE] = core_event.decode_done;
        set_vec[fxir_pkg::SRC_PROC]   = core_event.proc_done;
        set_vec[fxir_pkg::SRC_IMGOUT] = image_req & route.image_out_en;
        set_vec[fxir_pkg::SRC_IMGIN]  = image_req & route.image_in_en;
        // cleared by transfer counter reset write
        clr_vec[fxir_pkg::SRC_XFER]   = wr_xfer;
        clr_vec[fxir_pkg::SRC_CODE]   = rd_coded;
        clr_vec[fxir_pkg::SRC_DECODE] = rd_decode;
        // cleared by process counter reset write
        clr_vec[fxir_pkg::SRC_PROC]   = wr_proc;
        clr_vec[fxir_pkg::SRC_IMGOUT] = rd_image;
        clr_vec[fxir_pkg::SRC_IMGIN]  = wr_image;
    end

    // masked by mode and host enable
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_reg <= fxir_pkg::ENABLE_RESET;
        end else begin
            pend_reg <= ((pend_reg & ~clr_vec) | set_vec) & mode_allow & irq_enable;
        end
    end

    // recorder ready follows the input level
    logic [6:0] active;
    always_comb begin
        active = pend_reg;
        active[fxir_pkg::SRC_RECRDY] = recorder_ready_sync
            & mode_allow[fxir_pkg::SRC_RECRDY] & irq_enable[fxir_pkg::SRC_RECRDY];
    end

    logic [3:0] cause;
    always_comb begin
        if (active[fxir_pkg::SRC_XFER]) begin
            cause = fxir_pkg::CAUSE_XFER;
        end else if (|active[fxir_pkg::SRC_PROC:fxir_pkg::SRC_CODE]) begin
            cause = fxir_pkg::CAUSE_CODEC;
        end else if (active[fxir_pkg::SRC_RECRDY]) begin
            cause = fxir_pkg::CAUSE_RECRDY;
        end else if (|active[fxir_pkg::SRC_IMGIN:fxir_pkg::SRC_IMGOUT]) begin
            cause = fxir_pkg::CAUSE_IMAGE;
        end else begin
            cause = fxir_pkg::CAUSE_NONE;
        end
    end

    // request while anything enabled is pending
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |active;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // coded results and image data out on host bus
    // read data follows the synchronised address one cycle later
    // cause nibble at 1H, upper bits read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= fxir_pkg::DATA_RESET;
        end else if (addr_reg == fxir_pkg::ADDR_CAUSE_STATUS) begin
            rdata <= {4'h0, cause};
        end else if (addr_reg == fxir_pkg::ADDR_IMAGE_DATA) begin
            rdata <= route.image_out_en ? image_out_data : fxir_pkg::DATA_RESET;
        end else if (addr_reg == fxir_pkg::ADDR_DECODE_STATUS) begin
            rdata <= decode_status_in;
        end else if (addr_reg == fxir_pkg::ADDR_CODED_FIRST) begin
            rdata <= route.coded_out_en ? coded_first_in : fxir_pkg::DATA_RESET;
        end else begin
            rdata <= fxir_pkg::DATA_RESET;
        end
    end

endmodule : fxir_irq_route

`default_nettype wire

// >>> verilog/fxir_pkg.sv
// package for the facsimile codec interrupt and routing block
package fxir_pkg;

    // ****************************************************************
    // host bus register offsets
    // ****************************************************************
    localparam logic [3:0] ADDR_CAUSE_STATUS  = 4'h1;
    localparam logic [3:0] ADDR_IMAGE_DATA    = 4'h7;
    localparam logic [3:0] ADDR_DECODE_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CODED_FIRST   = 4'h9;
    localparam logic [3:0] ADDR_XFER_CLEAR    = 4'hC;
    localparam logic [3:0] ADDR_PROC_CLEAR    = 4'hE;

    // ****************************************************************
    // cause patterns and source indices
    // ****************************************************************
    localparam logic [3:0] CAUSE_NONE   = 4'h0;
    localparam logic [3:0] CAUSE_XFER   = 4'h1;
    localparam logic [3:0] CAUSE_CODEC  = 4'h2;
    localparam logic [3:0] CAUSE_RECRDY = 4'h4;
    localparam logic [3:0] CAUSE_IMAGE  = 4'h8;

    localparam int NUM_SRC    = 7;
    localparam int SRC_XFER   = 0;
    localparam int SRC_CODE   = 1;
    localparam int SRC_DECODE = 2;
    localparam int SRC_PROC   = 3;
    localparam int SRC_RECRDY = 4;
    localparam int SRC_IMGOUT = 5;
    localparam int SRC_IMGIN  = 6;

    localparam logic [6:0] ENABLE_RESET = 7'h00;
    localparam logic [7:0] DATA_RESET   = 8'h00;

    // ****************************************************************
    // operating modes
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_COPY    = 3'h0,
        MODE_G3_SEND = 3'h1,
        MODE_G2_SEND = 3'h2,
        MODE_G3_RECV = 3'h3,
        MODE_G2_RECV = 3'h4,
        MODE_G3_TO_G2 = 3'h5,
        MODE_G2_TO_G3 = 3'h6
    } fxir_mode_type;

    // one-cycle completion events from the codec core
    typedef struct packed {
        logic xfer_done;
        logic code_done;
        logic decode_done;
        logic proc_done;
    } fxir_event_type;

    // data path routing enables
    typedef struct packed {
        logic scan_in_en;
        logic rec_out_en;
        logic coded_out_en;
        logic decode_in_en;
        logic image_in_en;
        logic image_out_en;
    } fxir_route_type;

endpackage : fxir_pkg
